// ==== design/ucg_pkg.sv ====
package ucg_pkg;
  // register offsets inside one channel window
  localparam logic [4:0] OFF_DATA  = 5'h00;
  localparam logic [4:0] OFF_CTRLA = 5'h04;
  localparam logic [4:0] OFF_CTRLC = 5'h08;
  localparam logic [4:0] OFF_BAUDL = 5'h0C;
  localparam logic [4:0] OFF_BAUDH = 5'h10;
  localparam int         CHAN_BIT  = 5;
  localparam int         CHAN_NUM  = 2;
  // control_status_a fields
  localparam int A_DOUBLE  = 1;
  localparam int A_PARERR  = 2;
  localparam int A_OVERRUN = 3;
  localparam int A_FRMERR  = 4;
  localparam int A_TXEMPTY = 5;
  localparam int A_RXAVAIL = 7;
  // control_status_c fields
  localparam int C_POL     = 0;
  localparam int C_DIR     = 2;
  localparam int C_PARODD  = 4;
  localparam int C_PAREN   = 5;
  localparam int C_SYNC    = 6;
  localparam int C_PWRCUT  = 7;
  // reset values
  localparam logic [11:0] BAUD_RST = 12'h000;
  localparam logic [7:0]  BYTE_RST = 8'h00;
  // recovery state counts, last index and mid sample point
  localparam logic [3:0] LAST_NORMAL = 4'hF;
  localparam logic [3:0] LAST_DOUBLE = 4'h7;
  localparam logic [3:0] LAST_SYNC   = 4'h1;
  localparam logic [3:0] MID_NORMAL  = 4'h8;
  localparam logic [3:0] MID_DOUBLE  = 4'h4;
  // bits after start: data, optional parity, stop
  localparam logic [3:0] BITS_NOPAR  = 4'h9;
  localparam logic [3:0] BITS_PAR    = 4'hA;
  localparam logic [1:0] RXQ_DEPTH   = 2'h2;

  typedef enum {RX_IDLE, RX_START, RX_BITS} ucg_rx_e;

  typedef struct packed {
    logic rxd;
    logic xckIn;
  } ucg_pin_in_s;

  typedef struct packed {
    logic txd;
    logic xckOut;
    logic xckOe;
  } ucg_pin_out_s;

  typedef struct packed {
    logic pwrCut;
    logic sync;
    logic parEn;
    logic parOdd;
    logic dir;
    logic pol;
  } ucg_cfg_s;

  typedef struct packed {
    logic       pe;
    logic       fe;
    logic [7:0] data;
  } ucg_rxent_s;
endpackage : ucg_pkg

// ==== design/ucg_top.sv ====
// What this block does
// - four clock modes, sync select picks sync
// - in sync, clock direction picks master or slave
// - transfer clock pin idle in async modes
// - down-counter reloads at zero or low write
// - one baud pulse per counter zero
// - transmit clock is baud pulse over 2/8/16
// - receive recovery steps 2, 8 or 16 states
// - bit rate clock over 16/8/2 times divisor plus one
// - divisor is 12 bits from high/low
// - double speed uses 8 samples not 16
// - slave clock synchronised then edge detected
// - internal generator clocks async and master
// - single transmit buffer, back-to-back frames
// - two-level receive queue with error flags
// - two identical channels, separate registers
// - change on one edge, sample other
`timescale 1ns/1ps

module ucg_channel (
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  wrStb,
  input  wire logic                  rdStb,
  input  wire logic [4:0]            regOff,
  input  wire logic [7:0]            wrByte,
  output logic      [7:0]            rdByte,
  input  wire ucg_pkg::ucg_pin_in_s  pinIn,
  output ucg_pkg::ucg_pin_out_s      pinOut
);
  ucg_pkg::ucg_cfg_s   cfg_ff;
  logic                double_ff;
  logic [7:0]          baudLow_ff;
  logic [3:0]          baudHigh_ff;
  logic [11:0]         baudCnt_ff;
  logic                xckOut_ff;
  logic                xckOe_ff;
  logic                xs1_ff;
  logic                xs2_ff;
  logic                xPrev_ff;
  logic [3:0]          txPre_ff;
  logic [7:0]          txBuf_ff;
  logic                txFull_ff;
  logic [9:0]          txShift_ff;
  logic [3:0]          txLeft_ff;
  logic                txd_ff;
  ucg_pkg::ucg_rx_e    rxState_ff;
  logic [3:0]          rxPhase_ff;
  logic [9:0]          rxShift_ff;
  logic [3:0]          rxLeft_ff;
  ucg_pkg::ucg_rxent_s rxq_ff [2];
  logic [1:0]          rxCnt_ff;
  logic                overrun_ff;

  logic                hold;
  logic                wrData;
  logic                wrLow;
  logic [11:0]         baudDiv;
  logic                baudTick;
  logic                master;
  logic                slave;
  logic                dbl;
  logic [3:0]          stateLast;
  logic [3:0]          midPhase;
  logic                riseEv;
  logic                fallEv;
  logic                changeEv;
  logic                sampleEv;
  logic                txTick;
  logic                txLoad;
  logic                rxd;
  logic                rxSample;
  logic                rxDone;
  logic [9:0]          rxNext;
  ucg_pkg::ucg_rxent_s rxEnt;
  logic                rxPop;

  // power cut holds the channel like reset
  assign hold    = sys_rst | cfg_ff.pwrCut;
  assign wrData  = wrStb & (regOff == ucg_pkg::OFF_DATA);
  assign wrLow   = wrStb & (regOff == ucg_pkg::OFF_BAUDL);
  assign baudDiv = {baudHigh_ff, baudLow_ff};
  assign rxd     = pinIn.rxd;

  // mode decode
  assign master = cfg_ff.sync & cfg_ff.dir;
  assign slave  = cfg_ff.sync & ~cfg_ff.dir;
  assign dbl    = double_ff & ~cfg_ff.sync;
  always_comb begin
    if (cfg_ff.sync) begin
      stateLast = ucg_pkg::LAST_SYNC;
    end else if (dbl) begin
      stateLast = ucg_pkg::LAST_DOUBLE;
    end else begin
      stateLast = ucg_pkg::LAST_NORMAL;
    end
    midPhase = dbl ? ucg_pkg::MID_DOUBLE : ucg_pkg::MID_NORMAL;
  end

  // configuration registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cfg_ff      <= '0;
      double_ff   <= 1'b0;
      baudLow_ff  <= ucg_pkg::BYTE_RST;
      baudHigh_ff <= 4'h0;
    end else if (wrStb) begin
      if (regOff == ucg_pkg::OFF_CTRLA) begin
        double_ff <= wrByte[ucg_pkg::A_DOUBLE];
      end else if (regOff == ucg_pkg::OFF_CTRLC) begin
        cfg_ff.pwrCut <= wrByte[ucg_pkg::C_PWRCUT];
        cfg_ff.sync   <= wrByte[ucg_pkg::C_SYNC];
        cfg_ff.parEn  <= wrByte[ucg_pkg::C_PAREN];
        cfg_ff.parOdd <= wrByte[ucg_pkg::C_PARODD];
        cfg_ff.dir    <= wrByte[ucg_pkg::C_DIR];
        cfg_ff.pol    <= wrByte[ucg_pkg::C_POL];
      end else if (regOff == ucg_pkg::OFF_BAUDL) begin
        baudLow_ff <= wrByte;
      end else if (regOff == ucg_pkg::OFF_BAUDH) begin
        baudHigh_ff <= wrByte[3:0];
      end
    end
  end

  // baud down-counter
  assign baudTick = (baudCnt_ff == 12'h000);
  always_ff @(posedge core_clk) begin
    if (hold) begin
      baudCnt_ff <= ucg_pkg::BAUD_RST;
    end else if (wrLow) begin
      baudCnt_ff <= {baudHigh_ff, wrByte};
    end else if (baudTick) begin
      baudCnt_ff <= baudDiv;
    end else begin
      baudCnt_ff <= baudCnt_ff - 12'h001;
    end
  end

  // master clock out, toggles per baud pulse
  always_ff @(posedge core_clk) begin
    if (hold || !master) begin
      xckOut_ff <= 1'b0;
    end else if (baudTick) begin
      xckOut_ff <= ~xckOut_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (hold) begin
      xckOe_ff <= 1'b0;
    end else begin
      xckOe_ff <= master;
    end
  end

  // slave clock synchroniser and edge detector
  always_ff @(posedge core_clk) begin
    if (hold) begin
      xs1_ff   <= 1'b0;
      xs2_ff   <= 1'b0;
      xPrev_ff <= 1'b0;
    end else begin
      xs1_ff   <= pinIn.xckIn;
      xs2_ff   <= xs1_ff;
      xPrev_ff <= xs2_ff;
    end
  end

  // clock edges for synchronous modes
  always_comb begin
    riseEv = 1'b0;
    fallEv = 1'b0;
    if (master) begin
      riseEv = baudTick & ~xckOut_ff;
      fallEv = baudTick & xckOut_ff;
    end else if (slave) begin
      riseEv = xs2_ff & ~xPrev_ff;
      fallEv = ~xs2_ff & xPrev_ff;
    end
    changeEv = cfg_ff.pol ? fallEv : riseEv;
    sampleEv = cfg_ff.pol ? riseEv : fallEv;
  end

  // transmit prescaler for async modes
  always_ff @(posedge core_clk) begin
    if (hold) begin
      txPre_ff <= 4'h0;
    end else if (baudTick) begin
      txPre_ff <= (txPre_ff == stateLast) ? 4'h0 : txPre_ff + 4'h1;
    end
  end

  assign txTick = cfg_ff.sync ? changeEv
                              : (baudTick & (txPre_ff == stateLast));
  assign txLoad = txTick & (txLeft_ff == 4'h0) & txFull_ff;

  // transmit buffer, a write wins over a load
  always_ff @(posedge core_clk) begin
    if (hold) begin
      txFull_ff <= 1'b0;
      txBuf_ff  <= ucg_pkg::BYTE_RST;
    end else begin
      if (txLoad) begin
        txFull_ff <= 1'b0;
      end
      if (wrData) begin
        txFull_ff <= 1'b1;
        txBuf_ff  <= wrByte;
      end
    end
  end

  // transmit shifter, reloads straight after stop bit
  always_ff @(posedge core_clk) begin
    if (hold) begin
      txd_ff     <= 1'b1;
      txLeft_ff  <= 4'h0;
      txShift_ff <= 10'h3FF;
    end else if (txTick) begin
      if (txLeft_ff != 4'h0) begin
        txd_ff     <= txShift_ff[0];
        txShift_ff <= {1'b1, txShift_ff[9:1]};
        txLeft_ff  <= txLeft_ff - 4'h1;
      end else if (txFull_ff) begin
        txd_ff <= 1'b0;
        if (cfg_ff.parEn) begin
          txShift_ff <= {1'b1, ^txBuf_ff ^ cfg_ff.parOdd, txBuf_ff};
          txLeft_ff  <= ucg_pkg::BITS_PAR;
        end else begin
          txShift_ff <= {2'b11, txBuf_ff};
          txLeft_ff  <= ucg_pkg::BITS_NOPAR;
        end
      end
    end
  end

  // receive recovery phase counter
  always_ff @(posedge core_clk) begin
    if (hold || rxState_ff == ucg_pkg::RX_IDLE) begin
      rxPhase_ff <= 4'h0;
    end else if (baudTick) begin
      rxPhase_ff <= (rxPhase_ff == stateLast) ? 4'h0 : rxPhase_ff + 4'h1;
    end
  end

  assign rxSample = cfg_ff.sync ? sampleEv
                                : (baudTick & (rxPhase_ff == midPhase));
  assign rxNext   = {rxd, rxShift_ff[9:1]};

  // receive frame state machine
  always_ff @(posedge core_clk) begin
    if (hold) begin
      rxState_ff <= ucg_pkg::RX_IDLE;
      rxLeft_ff  <= 4'h0;
      rxShift_ff <= 10'h000;
    end else begin
      case (rxState_ff)
        ucg_pkg::RX_IDLE: begin
          if (cfg_ff.sync && sampleEv && !rxd) begin
            rxState_ff <= ucg_pkg::RX_BITS;
            rxLeft_ff  <= cfg_ff.parEn ? ucg_pkg::BITS_PAR : ucg_pkg::BITS_NOPAR;
          end else if (!cfg_ff.sync && baudTick && !rxd) begin
            rxState_ff <= ucg_pkg::RX_START;
          end
        end
        ucg_pkg::RX_START: begin
          if (rxSample) begin
            if (rxd) begin
              rxState_ff <= ucg_pkg::RX_IDLE;
            end else begin
              rxState_ff <= ucg_pkg::RX_BITS;
              rxLeft_ff  <= cfg_ff.parEn ? ucg_pkg::BITS_PAR : ucg_pkg::BITS_NOPAR;
            end
          end
        end
        default: begin
          if (rxSample) begin
            rxShift_ff <= rxNext;
            rxLeft_ff  <= rxLeft_ff - 4'h1;
            if (rxLeft_ff == 4'h1) begin
              rxState_ff <= ucg_pkg::RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // completed frame and its error checks
  assign rxDone = (rxState_ff == ucg_pkg::RX_BITS) & rxSample & (rxLeft_ff == 4'h1);
  always_comb begin
    rxEnt.fe = ~rxNext[9];
    if (cfg_ff.parEn) begin
      rxEnt.data = rxNext[7:0];
      rxEnt.pe   = rxNext[8] ^ (^rxNext[7:0]) ^ cfg_ff.parOdd;
    end else begin
      rxEnt.data = rxNext[8:1];
      rxEnt.pe   = 1'b0;
    end
  end

  assign rxPop = rdStb & (regOff == ucg_pkg::OFF_DATA) & (rxCnt_ff != 2'h0);

  // two-level receive queue
  always_ff @(posedge core_clk) begin
    if (hold) begin
      rxCnt_ff <= 2'h0;
    end else if (rxDone && !rxPop) begin
      if (rxCnt_ff != ucg_pkg::RXQ_DEPTH) begin
        rxq_ff[rxCnt_ff[0]] <= rxEnt;
        rxCnt_ff            <= rxCnt_ff + 2'h1;
      end
    end else if (rxPop && !rxDone) begin
      rxq_ff[0] <= rxq_ff[1];
      rxCnt_ff  <= rxCnt_ff - 2'h1;
    end else if (rxPop && rxDone) begin
      if (rxCnt_ff == 2'h1) begin
        rxq_ff[0] <= rxEnt;
      end else begin
        rxq_ff[0] <= rxq_ff[1];
        rxq_ff[1] <= rxEnt;
      end
    end
  end

  // overrun flag, clear by read wins over set
  always_ff @(posedge core_clk) begin
    if (hold) begin
      overrun_ff <= 1'b0;
    end else if (rxDone && !rxPop && rxCnt_ff == ucg_pkg::RXQ_DEPTH) begin
      overrun_ff <= 1'b1;
    end else if (rxPop) begin
      overrun_ff <= 1'b0;
    end
  end

  // register read mux
  always_comb begin
    rdByte = ucg_pkg::BYTE_RST;
    if (regOff == ucg_pkg::OFF_DATA) begin
      rdByte = (rxCnt_ff != 2'h0) ? rxq_ff[0].data : ucg_pkg::BYTE_RST;
    end else if (regOff == ucg_pkg::OFF_CTRLA) begin
      rdByte[ucg_pkg::A_RXAVAIL] = (rxCnt_ff != 2'h0);
      rdByte[ucg_pkg::A_TXEMPTY] = ~txFull_ff;
      rdByte[ucg_pkg::A_FRMERR]  = (rxCnt_ff != 2'h0) & rxq_ff[0].fe;
      rdByte[ucg_pkg::A_OVERRUN] = overrun_ff;
      rdByte[ucg_pkg::A_PARERR]  = (rxCnt_ff != 2'h0) & rxq_ff[0].pe;
      rdByte[ucg_pkg::A_DOUBLE]  = double_ff;
    end else if (regOff == ucg_pkg::OFF_CTRLC) begin
      rdByte[ucg_pkg::C_PWRCUT] = cfg_ff.pwrCut;
      rdByte[ucg_pkg::C_SYNC]   = cfg_ff.sync;
      rdByte[ucg_pkg::C_PAREN]  = cfg_ff.parEn;
      rdByte[ucg_pkg::C_PARODD] = cfg_ff.parOdd;
      rdByte[ucg_pkg::C_DIR]    = cfg_ff.dir;
      rdByte[ucg_pkg::C_POL]    = cfg_ff.pol;
    end else if (regOff == ucg_pkg::OFF_BAUDL) begin
      rdByte = baudLow_ff;
    end else if (regOff == ucg_pkg::OFF_BAUDH) begin
      rdByte = {4'h0, baudHigh_ff};
    end
  end

  assign pinOut.txd    = txd_ff;
  assign pinOut.xckOut = xckOut_ff;
  assign pinOut.xckOe  = xckOe_ff;
endmodule : ucg_channel

module ucg_top (
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire ucg_pkg::ucg_pin_in_s  pinIn [2],
  output ucg_pkg::ucg_pin_out_s      pinOut [2]
);
  logic        ack_ff;
  logic [31:0] datOut_ff;
  logic        wbReq;
  logic        inMap;
  logic [7:0]  rdByte [2];
  logic        chanSel;

  assign wbReq   = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign inMap   = (wb_adr_i[7:6] == 2'h0);
  assign chanSel = wb_adr_i[ucg_pkg::CHAN_BIT];

  // two identical channels
  for (genvar i = 0; i < ucg_pkg::CHAN_NUM; i++) begin : g_chan
    ucg_channel u_chan (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .wrStb    (wbReq & wb_we_i & wb_sel_i[0] & inMap & (chanSel == 1'(i))),
      .rdStb    (wbReq & ~wb_we_i & inMap & (chanSel == 1'(i))),
      .regOff   (wb_adr_i[4:0]),
      .wrByte   (wb_dat_i[7:0]),
      .rdByte   (rdByte[i]),
      .pinIn    (pinIn[i]),
      .pinOut   (pinOut[i])
    );
  end

  // single-wait-state acknowledge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wbReq;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      datOut_ff <= 32'h0000_0000;
    end else if (wbReq && !wb_we_i) begin
      datOut_ff <= inMap ? {24'h00_0000, rdByte[chanSel]} : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = datOut_ff;
endmodule : ucg_top

// ==== tb/ucg_peer.sv ====
`timescale 1ns/1ps

module ucg_peer #(
  parameter int HALF = 8
) (
  input  wire logic                  core_clk,
  output ucg_pkg::ucg_pin_in_s       pinIn [2],
  input  wire ucg_pkg::ucg_pin_out_s pinOut [2]
);
  initial begin
    for (int i = 0; i < 2; i++) begin
      pinIn[i].rxd   = 1'b1;
      pinIn[i].xckIn = 1'b0;
    end
  end

  task automatic sendAsync(input int ch, input logic [7:0] d, input logic stop, input int bc);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      pinIn[ch].rxd <= f[i];
      repeat (bc) @(posedge core_clk);
    end
    pinIn[ch].rxd <= 1'b1;
    @(posedge core_clk);
  endtask : sendAsync

  // clock stands low before and after its 20 periods, 10 beyond the frame
  task automatic slaveXfer(input int ch, input logic [7:0] d, output logic [7:0] q);
    logic [9:0] f;
    int         s;
    f = {1'b1, d, 1'b0};
    s = 0;
    q = 8'h00;
    for (int i = 0; i < 20; i++) begin
      pinIn[ch].rxd   <= (i < 10) ? f[i] : 1'b1;
      pinIn[ch].xckIn <= 1'b1;
      repeat (HALF) @(posedge core_clk);
      pinIn[ch].xckIn <= 1'b0;
      if (s > 0 && s < 9) q[s - 1] = pinOut[ch].txd;
      if (s > 0 || pinOut[ch].txd === 1'b0) s++;
      repeat (HALF) @(posedge core_clk);
    end
  endtask : slaveXfer
endmodule : ucg_peer

// ==== tb/ucg_top_asserts.sv ====
`timescale 1ns/1ps

module ucg_top_asserts (
  input wire logic                  core_clk,
  input wire logic                  sys_rst,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic [7:0]            wb_adr_i,
  input wire logic                  wb_ack_o,
  input wire ucg_pkg::ucg_pin_out_s pinOut [2]
);
  logic [1:0] xckHist_ff;

  always_ff @(posedge core_clk) begin
    xckHist_ff <= {xckHist_ff[0], pinOut[0].xckOut};
  end

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_oe_ch0: assert property ($changed(pinOut[0].xckOe) |->
    $past(wb_we_i && wb_stb_i && wb_adr_i == 8'h08, 1) ||
    $past(wb_we_i && wb_stb_i && wb_adr_i == 8'h08, 2))
    else $error("channel 0 clock enable moved without control write");
  chk_oe_ch1: assert property ($changed(pinOut[1].xckOe) |->
    $past(wb_we_i && wb_stb_i && wb_adr_i == 8'h28, 1) ||
    $past(wb_we_i && wb_stb_i && wb_adr_i == 8'h28, 2))
    else $error("channel 1 clock enable moved without its control write");
  chk_reset_idle: assert property ($fell(sys_rst) |->
    pinOut[0].txd && !pinOut[0].xckOe && pinOut[1].txd && !wb_ack_o)
    else $error("outputs not idle out of reset");
  chk_low_width: assert property ($fell(pinOut[0].txd) && !pinOut[0].xckOe |->
    (!pinOut[0].txd) [*8])
    else $error("transmit bit shorter than eight cycles");
  chk_txd_edge: assert property (pinOut[0].xckOe && $changed(pinOut[0].txd) |->
    (pinOut[0].xckOut && !xckHist_ff[0]) || (xckHist_ff[0] && !xckHist_ff[1]))
    else $error("master data changed away from rising clock");
endmodule : ucg_top_asserts

bind ucg_top ucg_top_asserts chk_u (.core_clk(core_clk), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_ack_o(wb_ack_o), .pinOut(pinOut));

// ==== tb/tb_ucg_top.sv ====
`timescale 1ns/1ps

module tb_ucg_top;
  localparam int         LIMIT = 30000;
  localparam logic [4:0] DT = ucg_pkg::OFF_DATA;
  localparam logic [4:0] CA = ucg_pkg::OFF_CTRLA;
  localparam logic [4:0] CC = ucg_pkg::OFF_CTRLC;
  localparam logic [4:0] BL = ucg_pkg::OFF_BAUDL;
  localparam logic [4:0] BH = ucg_pkg::OFF_BAUDH;
  logic                  core_clk;
  logic                  sys_rst;
  logic                  cyc;
  logic                  stb;
  logic                  we;
  logic [7:0]            adr;
  logic [3:0]            sel;
  logic [31:0]           dat;
  logic [31:0]           wb_dat_o;
  logic                  wb_ack_o;
  ucg_pkg::ucg_pin_in_s  pinIn [2];
  ucg_pkg::ucg_pin_out_s pinOut [2];
  int                    cycles;
  int                    n_fail;
  int                    n_compared;

  ucg_top dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pinIn(pinIn), .pinOut(pinOut));
  ucg_peer peer_u (.core_clk(core_clk), .pinIn(pinIn), .pinOut(pinOut));

  function automatic logic [7:0] ra(input int ch, input logic [4:0] off);
    return {2'b00, ch[0], off};
  endfunction : ra

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [15:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h00_0000, d};
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1) begin
      @(posedge core_clk);
    end
    q = wb_dat_o[15:0];
    chk("ack", 16'h0001, {15'h0000, wb_ack_o});
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rdChk(input string n, input logic [7:0] a, input logic [15:0] e);
    logic [15:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(n, e, q);
  endtask : rdChk

  task automatic waitEmpty(input int ch);
    logic [15:0] q;
    int          n;
    n = 0;
    q = 16'h0000;
    while (q[5] !== 1'b1 && n < 100) begin
      wb(1'b0, ra(ch, CA), 8'h00, q);
      n++;
    end
  endtask : waitEmpty

  task automatic getFrame(input int ch, input int bc, output logic [7:0] b, output int t);
    int n;
    n = 0;
    while (pinOut[ch].txd !== 1'b0 && n < 4000) begin
      @(posedge core_clk);
      n++;
    end
    t = int'($time / 10);
    repeat (bc / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bc) @(posedge core_clk);
      b[i] = pinOut[ch].txd;
    end
  endtask : getFrame

  task automatic waitXck(output int t);
    logic v;
    int   n;
    v = pinOut[0].xckOut;
    n = 0;
    while (pinOut[0].xckOut === v && n < 600) begin
      @(posedge core_clk);
      n++;
    end
    t = int'($time / 10);
  endtask : waitXck

  task automatic syncCap(output logic [7:0] b);
    int n;
    n = 0;
    do begin
      @(negedge pinOut[0].xckOut);
      n++;
    end while (pinOut[0].txd !== 1'b0 && n < 60);
    for (int i = 0; i < 8; i++) begin
      @(negedge pinOut[0].xckOut);
      b[i] = pinOut[0].txd;
    end
    @(posedge core_clk);
  endtask : syncCap

  task automatic t_regs();
    rdChk("ctrl_a", ra(0, CA), 16'h0020);
    rdChk("ctrl_c", ra(1, CC), 16'h0000);
    rdChk("baud_low", ra(0, BL), 16'h0000);
    rdChk("unmapped", 8'h48, 16'h0000);
    sel <= 4'h0;
    wr(ra(0, CC), 8'h30);
    sel <= 4'h1;
    rdChk("sel_off", ra(0, CC), 16'h0000);
    wr(ra(1, CC), 8'h30);
    rdChk("ch1_ctrl", ra(1, CC), 16'h0030);
    rdChk("ch0_ctrl", ra(0, CC), 16'h0000);
    wr(ra(1, CC), 8'hC4);
    wr(ra(1, DT), 8'h55);
    rdChk("cut_held", ra(1, CA), 16'h0020);
    chk("oe_cut", 16'h0000, {15'h0000, pinOut[1].xckOe});
    wr(ra(1, CC), 8'h44);
    chk("oe_ch1", 16'h0001, {15'h0000, pinOut[1].xckOe});
    wr(ra(1, CC), 8'h00);
    $display("done regs");
  endtask : t_regs

  task automatic t_async();
    logic [7:0] b0;
    logic [7:0] b1;
    int         t0;
    int         t1;
    int         bc;
    for (int ch = 0; ch < 2; ch++) begin
      for (int m = 0; m < 2; m++) begin
        bc = (m == 1) ? 24 : 48;
        wr(ra(ch, BH), 8'h00);
        wr(ra(ch, BL), 8'h02);
        wr(ra(ch, CA), (m == 1) ? 8'h02 : 8'h00);
        fork
          begin
            getFrame(ch, bc, b0, t0);
            getFrame(ch, bc, b1, t1);
          end
          begin
            wr(ra(ch, DT), 8'hA5);
            waitEmpty(ch);
            wr(ra(ch, DT), 8'h3C);
          end
        join
        chk("tx_first", 16'h00A5, {8'h00, b0});
        chk("tx_second", 16'h003C, {8'h00, b1});
        chk("frame_span", 16'(10 * bc), 16'(t1 - t0));
        peer_u.sendAsync(ch, 8'h69, 1'b1, bc);
        rdChk("rx_flags", ra(ch, CA), (m == 1) ? 16'h00A2 : 16'h00A0);
        rdChk("rx_data", ra(ch, DT), 16'h0069);
        rdChk("rx_empty", ra(ch, CA), (m == 1) ? 16'h0022 : 16'h0020);
      end
      wr(ra(ch, CA), 8'h00);
    end
    $display("done async");
  endtask : t_async

  task automatic t_overrun();
    peer_u.sendAsync(0, 8'h44, 1'b0, 48);
    repeat (100) @(posedge core_clk);
    peer_u.sendAsync(0, 8'h11, 1'b1, 48);
    peer_u.sendAsync(0, 8'h33, 1'b1, 48);
    rdChk("err_flags", ra(0, CA), 16'h00B8);
    rdChk("rx_head", ra(0, DT), 16'h0044);
    rdChk("ovr_clear", ra(0, CA), 16'h00A0);
    rdChk("rx_next", ra(0, DT), 16'h0011);
    rdChk("rx_drained", ra(0, CA), 16'h0020);
    wr(ra(0, CC), 8'h20);
    peer_u.sendAsync(0, 8'h69, 1'b1, 48);
    repeat (48) @(posedge core_clk);
    rdChk("par_err", ra(0, CA), 16'h00A4);
    rdChk("par_data", ra(0, DT), 16'h0069);
    wr(ra(0, CC), 8'h00);
    $display("done overrun");
  endtask : t_overrun

  task automatic t_master();
    logic [7:0] b;
    int         t0;
    int         t1;
    wr(ra(0, BH), 8'h01);
    wr(ra(0, BL), 8'h00);
    wr(ra(0, CC), 8'h44);
    chk("oe_master", 16'h0001, {15'h0000, pinOut[0].xckOe});
    waitXck(t0);
    waitXck(t0);
    waitXck(t1);
    chk("half_period", 16'h0101, 16'(t1 - t0));
    wr(ra(0, BH), 8'h00);
    wr(ra(0, BL), 8'h03);
    wr(ra(0, DT), 8'h96);
    syncCap(b);
    chk("sync_tx", 16'h0096, {8'h00, b});
    wr(ra(0, CC), 8'h00);
    chk("oe_async", 16'h0000, {15'h0000, pinOut[0].xckOe});
    $display("done master");
  endtask : t_master

  task automatic t_slave();
    logic [7:0] q;
    wr(ra(0, CC), 8'h40);
    wr(ra(0, DT), 8'hC3);
    peer_u.slaveXfer(0, 8'h5A, q);
    chk("slave_tx", 16'h00C3, {8'h00, q});
    chk("oe_slave", 16'h0000, {15'h0000, pinOut[0].xckOe});
    rdChk("slave_rx", ra(0, DT), 16'h005A);
    wr(ra(0, CC), 8'h00);
    $display("done slave");
  endtask : t_slave

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_fail = n_fail + 1;
      conclude();
    end
  end

  initial begin
    sys_rst    = 1'b1;
    cyc        = 1'b0;
    stb        = 1'b0;
    we         = 1'b0;
    adr        = 8'h00;
    sel        = 4'h1;
    dat        = 32'h0000_0000;
    cycles     = 0;
    n_fail     = 0;
    n_compared = 0;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    t_regs();
    t_async();
    t_overrun();
    t_master();
    t_slave();
    conclude();
  end
endmodule : tb_ucg_top
